// file: include/codec_port_pkg.sv
// Register map, field layout and timing constants of the codec serial port.
package codec_port_pkg;

    // Register indices; each register sits at byte address index * 4.
    localparam logic [7:0] IDX_DIG_POWER = 8'h02;
    localparam logic [7:0] IDX_CLK_CTRL  = 8'h04;
    localparam logic [7:0] IDX_PORT_CTRL = 8'h06;
    localparam logic [7:0] IDX_STATUS    = 8'h08;

    localparam logic [7:0] ADDR_DIG_POWER = IDX_DIG_POWER << 2;
    localparam logic [7:0] ADDR_CLK_CTRL  = IDX_CLK_CTRL << 2;
    localparam logic [7:0] ADDR_PORT_CTRL = IDX_PORT_CTRL << 2;
    localparam logic [7:0] ADDR_STATUS    = IDX_STATUS << 2;

    localparam logic [15:0] RST_DIG_POWER  = 16'h0000;
    localparam logic [15:0] RST_CLK_CTRL   = 16'h0008;
    localparam logic [15:0] RST_PORT_CTRL  = 16'h0010;
    localparam logic [15:0] MASK_DIG_POWER = 16'h007f;
    localparam logic [15:0] MASK_CLK_CTRL  = 16'h003f;
    localparam logic [15:0] MASK_PORT_CTRL = 16'h01ff;

    // Digital block power fields.
    localparam int BIT_REC_PWR  = 6;
    localparam int BIT_PLAY_PWR = 5;
    localparam int BIT_DSP_PWR  = 4;
    localparam int BIT_OUT_EN   = 1;
    localparam int BIT_IN_EN    = 0;

    // Clock rate control fields.
    localparam int RATE_DIV_MSB = 5;
    localparam int RATE_DIV_LSB = 4;
    localparam int BASE_FS_MSB  = 3;
    localparam int BASE_FS_LSB  = 2;
    localparam int MCLK_MSB     = 1;
    localparam int MCLK_LSB     = 0;
    localparam logic [1:0] MCLK_USE_PLL = 2'h3;

    // Serial port control fields.
    localparam int BIT_BCLK_RATE = 8;
    localparam int BIT_MASTER    = 7;
    localparam int BIT_EDGE      = 6;
    localparam int WLEN_MSB      = 5;
    localparam int WLEN_LSB      = 4;
    localparam int FMT_MSB       = 3;
    localparam int FMT_LSB       = 2;
    localparam int BIT_ALIGN     = 1;
    localparam int BIT_POL       = 0;

    localparam logic [1:0] FMT_I2S_LJ = 2'h0;
    localparam logic [1:0] FMT_RJ     = 2'h1;
    localparam logic [1:0] FMT_PCM    = 2'h2;

    localparam logic [6:0] WLEN_32 = 7'h20;
    localparam logic [6:0] WLEN_24 = 7'h18;
    localparam logic [6:0] WLEN_20 = 7'h14;
    localparam logic [6:0] WLEN_16 = 7'h10;
    localparam logic [6:0] SLOT_64FS = 7'h20;
    localparam logic [6:0] SLOT_32FS = 7'h10;

    // Timing: system clock and base sample rates in Hz.
    localparam int CLK_HZ        = 100_000_000;
    localparam int FS_32K_HZ     = 32000;
    localparam int FS_44K_HZ     = 44100;
    localparam int FS_48K_HZ     = 48000;
    localparam int FS_96K_HZ     = 96000;
    localparam int BCLK_PER_FS   = 64;
    localparam logic [11:0] HALF_32K = 12'(CLK_HZ / (FS_32K_HZ * BCLK_PER_FS * 2));
    localparam logic [11:0] HALF_44K = 12'(CLK_HZ / (FS_44K_HZ * BCLK_PER_FS * 2));
    localparam logic [11:0] HALF_48K = 12'(CLK_HZ / (FS_48K_HZ * BCLK_PER_FS * 2));
    localparam logic [11:0] HALF_96K = 12'(CLK_HZ / (FS_96K_HZ * BCLK_PER_FS * 2));
    localparam logic [11:0] DIV_1 = 12'h001;
    localparam logic [11:0] DIV_2 = 12'h002;
    localparam logic [11:0] DIV_4 = 12'h004;
    localparam logic [11:0] DIV_6 = 12'h006;

    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [1:0] {
        FR_SEARCH = 2'b01,
        FR_LOCKED = 2'b10
    } frame_state_t;

endpackage

// file: src/bclk_divider.sv
// Half bit clock period divider producing one-cycle enable pulses.
`timescale 1ns/100ps
module bclk_divider
    import codec_port_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        enable,
    input  wire logic [11:0] half_count,
    output logic             tick
);

    logic [11:0] count;

    // A shortened half period takes effect at once, so the count compares
    // with greater-or-equal rather than equality.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count <= 12'h000;
        end else if (!enable) begin
            count <= 12'h000;
        end else if (count >= half_count - 12'h001) begin
            count <= 12'h000;
        end else begin
            count <= count + 12'h001;
        end
    end

    assign tick = enable && (count >= half_count - 12'h001);

endmodule

// file: src/codec_serial_port.sv
// Codec digital power, clock rate and serial audio port with AHB-Lite regs.
//
// Function
// - Record converter powered only while power bit 6 is set.
// - Playback converter powered only while power bit 5 is set.
// - Audio processor runs only while power bit 4 is set.
// - Serial data is driven out only while power bit 1 is set.
// - Serial data is accepted only while power bit 0 is set.
// - Rate divider bits 5:4 give full, half, quarter or sixth rate.
// - Base rate bits 3:2 select 32, 44.1, 48, 96 kHz; reset 48.
// - Clock ratio bits 1:0 give 256, 384, 512 Fs or PLL.
// - As master, bit clock is 64 Fs with bit 8 clear, 32 Fs set.
// - Bit 7 set drives both port clocks out, clear takes them in.
// - Bit 6 picks rising or falling bit clock edge for valid data.
// - Word length bits 5:4 give 32, 24, 20, 16 bits; reset 24.
// - Format bits 3:2 give I2S/left, right-justified, PCM; 3 reserved.
// - Bit 1 clear delays the word one bit clock, set starts at once; right-justified ignores it.
// - Bit 0 sets which frame clock level marks the left channel.
// - The left subframe always goes before the right one.
`timescale 1ns/100ps
module codec_serial_port
    import codec_port_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             record_converter_power_on,
    output logic             playback_converter_power_on,
    output logic             audio_processor_power_on,
    output logic [1:0]       base_sample_rate,
    output logic [1:0]       rate_divider,
    output logic [1:0]       master_clock_ratio,
    output logic             pll_clock_select,
    input  wire logic        bclk_in,
    output logic             bclk_out,
    output logic             bclk_oe,
    input  wire logic        lrclk_in,
    output logic             lrclk_out,
    output logic             lrclk_oe,
    input  wire logic        sdata_in,
    output logic             sdata_out,
    input  wire logic [31:0] tx_left,
    input  wire logic [31:0] tx_right,
    output logic             tx_taken,
    output logic [31:0]      rx_left,
    output logic [31:0]      rx_right,
    output logic             rx_valid
);

    ////////////////////////////////////////////////////////////////////////
    logic [15:0]  digital_block_power;
    logic [15:0]  clock_rate_control;
    logic [15:0]  serial_port_control;
    logic [15:0]  next_power;
    logic [15:0]  next_clock;
    logic [15:0]  next_port;
    logic         wr_pend;
    logic [7:0]   wr_addr;
    logic         take;
    logic [15:0]  status_word;

    logic         serial_output_enable;
    logic         serial_input_enable;
    logic         bit_clock_rate_select;
    logic         clock_master_select;
    logic         bit_clock_edge_select;
    logic [1:0]   word_length_select;
    logic [1:0]   format_select;
    logic         frame_alignment_select;
    logic         channel_clock_polarity;

    logic [6:0]   wlen;
    logic [6:0]   slot;
    logic [6:0]   frame_last;
    logic [6:0]   base_l;
    logic [6:0]   base_r;
    logic [11:0]  half_count;
    logic         div_tick;
    logic         bphase;
    logic         bclk_prev;
    logic         frame_clk;
    logic         valid_ev;
    logic         launch_ev;
    logic [6:0]   bit_index;
    logic [6:0]   next_index;
    logic [6:0]   loc_next;
    logic [6:0]   loc_now;
    logic         lr_now;
    logic         mark_now;
    logic         mark_prev;
    logic         start_seen;
    frame_state_t frame_state;
    logic [31:0]  tx_hold_l;
    logic [31:0]  tx_hold_r;
    logic [31:0]  src_l;
    logic [31:0]  src_r;
    logic [31:0]  rx_l_sh;
    logic [31:0]  rx_r_sh;

    ////////////////////////////////////////////////////////////////////////
    // Zero wait state slave: every transfer completes with OKAY.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign take      = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else if (hready) begin
            wr_pend <= take && hwrite && (haddr[31:8] == 24'h000000);
            wr_addr <= haddr[7:0];
        end
    end

    // The write lands in the data phase; the read mux sees the new value so
    // a read right behind a write to the same register is not stale.
    always_comb begin
        next_power = digital_block_power;
        next_clock = clock_rate_control;
        next_port  = serial_port_control;
        if (wr_pend && wr_addr == ADDR_DIG_POWER) begin
            next_power = hwdata[15:0] & MASK_DIG_POWER;
        end
        if (wr_pend && wr_addr == ADDR_CLK_CTRL) begin
            next_clock = hwdata[15:0] & MASK_CLK_CTRL;
        end
        if (wr_pend && wr_addr == ADDR_PORT_CTRL) begin
            next_port = hwdata[15:0] & MASK_PORT_CTRL;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            digital_block_power <= RST_DIG_POWER;
            clock_rate_control  <= RST_CLK_CTRL;
            serial_port_control <= RST_PORT_CTRL;
        end else begin
            digital_block_power <= next_power;
            clock_rate_control  <= next_clock;
            serial_port_control <= next_port;
        end
    end

    assign status_word = {7'h00, frame_state == FR_LOCKED, lr_now, bit_index};

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hrdata <= 32'h00000000;
        end else if (take && !hwrite) begin
            if (haddr[31:8] != 24'h000000) begin
                hrdata <= 32'h00000000;
            end else begin
                unique case (haddr[7:0])
                    ADDR_DIG_POWER: hrdata <= {16'h0000, next_power};
                    ADDR_CLK_CTRL:  hrdata <= {16'h0000, next_clock};
                    ADDR_PORT_CTRL: hrdata <= {16'h0000, next_port};
                    ADDR_STATUS:    hrdata <= {16'h0000, status_word};
                    default:        hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign record_converter_power_on   = digital_block_power[BIT_REC_PWR];
    assign playback_converter_power_on = digital_block_power[BIT_PLAY_PWR];
    assign audio_processor_power_on    = digital_block_power[BIT_DSP_PWR];
    assign serial_output_enable        = digital_block_power[BIT_OUT_EN];
    assign serial_input_enable         = digital_block_power[BIT_IN_EN];

    assign rate_divider       = clock_rate_control[RATE_DIV_MSB:RATE_DIV_LSB];
    assign base_sample_rate   = clock_rate_control[BASE_FS_MSB:BASE_FS_LSB];
    assign master_clock_ratio = clock_rate_control[MCLK_MSB:MCLK_LSB];
    assign pll_clock_select   = (master_clock_ratio == MCLK_USE_PLL);

    assign bit_clock_rate_select  = serial_port_control[BIT_BCLK_RATE];
    assign clock_master_select    = serial_port_control[BIT_MASTER];
    assign bit_clock_edge_select  = serial_port_control[BIT_EDGE];
    assign word_length_select     = serial_port_control[WLEN_MSB:WLEN_LSB];
    assign format_select          = serial_port_control[FMT_MSB:FMT_LSB];
    assign frame_alignment_select = serial_port_control[BIT_ALIGN];
    assign channel_clock_polarity = serial_port_control[BIT_POL];

    // Half bit clock period; the ratio field does not enter here because
    // the bit clock is built from the system clock, not the master clock.
    function automatic logic [11:0] half_period(input logic [1:0] fs,
                                                input logic [1:0] div,
                                                input logic       b32);
        logic [11:0] base;
        logic [11:0] mult;
        unique case (fs)
            2'h0: base = HALF_32K;
            2'h1: base = HALF_44K;
            2'h2: base = HALF_48K;
            2'h3: base = HALF_96K;
        endcase
        unique case (div)
            2'h0: mult = DIV_1;
            2'h1: mult = DIV_2;
            2'h2: mult = DIV_4;
            2'h3: mult = DIV_6;
        endcase
        if (b32) begin
            return 12'(base * mult * DIV_2);
        end
        return 12'(base * mult);
    endfunction

    assign half_count = half_period(base_sample_rate, rate_divider,
                                    bit_clock_rate_select);

    bclk_divider u_divider (
        .clk        (clk),
        .nrst       (nrst),
        .enable     (clock_master_select),
        .half_count (half_count),
        .tick       (div_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Frame geometry: slot width, word length and word start positions.
    always_comb begin
        unique case (word_length_select)
            2'h0: wlen = WLEN_32;
            2'h1: wlen = WLEN_24;
            2'h2: wlen = WLEN_20;
            2'h3: wlen = WLEN_16;
        endcase
        // In slave mode the slot width relies on the rate bit matching.
        slot       = bit_clock_rate_select ? SLOT_32FS : SLOT_64FS;
        frame_last = (slot << 1) - 7'h01;
        // Right-justified start underflows if 20, 24 or 32 bits meet a 32 Fs slot.
        if (format_select == FMT_RJ) begin
            base_l = slot - wlen;
        end else begin
            base_l = {6'h00, ~frame_alignment_select};
        end
        if (format_select == FMT_PCM) begin
            base_r = base_l + wlen;
        end else begin
            base_r = base_l + slot;
        end
    end

    // Maps a bit period to {in word, right channel, word bit number}.
    function automatic logic [6:0] locate(input logic [6:0] n);
        logic       right;
        logic       hit;
        logic [6:0] off;
        logic [6:0] bitn;
        right = (n >= base_r);
        off   = right ? n - base_r : n - base_l;
        hit   = (n >= base_l) && (off < wlen);
        bitn  = wlen - off - 7'h01;
        return {hit, right, bitn[4:0]};
    endfunction

    // Frame clock level a master drives for a given bit period.
    function automatic logic frame_level(input logic [6:0] n);
        if (format_select == FMT_PCM) begin
            return (n == 7'h00) ^ channel_clock_polarity;
        end
        return (n >= slot) ^ channel_clock_polarity;
    endfunction

    assign next_index = (bit_index >= frame_last) ? 7'h00 : bit_index + 7'h01;
    assign loc_next   = locate(next_index);
    assign loc_now    = locate(bit_index);

    ////////////////////////////////////////////////////////////////////////
    // Bit clock edges: from the divider as master, from the pin as slave.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bphase <= 1'b0;
        end else if (!clock_master_select) begin
            bphase <= 1'b0;
        end else if (div_tick) begin
            bphase <= ~bphase;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bclk_prev <= 1'b0;
        end else begin
            bclk_prev <= bclk_in;
        end
    end

    always_comb begin
        if (clock_master_select) begin
            valid_ev  = div_tick && !bphase;
            launch_ev = div_tick && bphase;
        end else if (bit_clock_edge_select) begin
            valid_ev  = bclk_prev && !bclk_in;
            launch_ev = !bclk_prev && bclk_in;
        end else begin
            valid_ev  = !bclk_prev && bclk_in;
            launch_ev = bclk_prev && !bclk_in;
        end
    end

    // The valid edge is the transition into bphase high.
    assign bclk_out = clock_master_select && (bphase ^ bit_clock_edge_select);
    assign bclk_oe  = clock_master_select;
    assign lrclk_oe = clock_master_select;

    ////////////////////////////////////////////////////////////////////////
    // The frame starts where the frame clock enters the left level, or on
    // the leading edge of the PCM sync pulse.
    assign lr_now     = clock_master_select ? lrclk_out : lrclk_in;
    assign mark_now   = (format_select == FMT_PCM) ?
                        (lr_now ^ channel_clock_polarity) :
                        ~(lr_now ^ channel_clock_polarity);
    assign start_seen = mark_now && !mark_prev;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mark_prev <= 1'b1;
        end else if (valid_ev) begin
            mark_prev <= mark_now;
        end
    end

    // A slave predicts the next period and resyncs on a seen frame start;
    // the frame in which a resync happens is not reported.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bit_index <= 7'h00;
        end else if (launch_ev) begin
            bit_index <= next_index;
        end else if (valid_ev && !clock_master_select && start_seen) begin
            bit_index <= 7'h00;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            frame_state <= FR_SEARCH;
        end else if (clock_master_select) begin
            frame_state <= FR_LOCKED;
        end else if (valid_ev && start_seen) begin
            unique case (frame_state)
                FR_SEARCH: frame_state <= (bit_index == 7'h00) ?
                                          FR_LOCKED : FR_SEARCH;
                FR_LOCKED: frame_state <= (bit_index == 7'h00) ?
                                          FR_LOCKED : FR_SEARCH;
                default:   frame_state <= FR_SEARCH;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            frame_clk <= 1'b0;
        end else if (!clock_master_select) begin
            frame_clk <= 1'b0;
        end else if (launch_ev) begin
            frame_clk <= frame_level(next_index);
        end
    end

    // Gated so the pin drops with its enable, not one cycle later.
    assign lrclk_out = clock_master_select && frame_clk;

    ////////////////////////////////////////////////////////////////////////
    // Transmit: words are taken at the first period of each frame, and the
    // port words are used directly for that period so nothing lags a frame.
    assign src_l = (next_index == 7'h00) ? tx_left : tx_hold_l;
    assign src_r = (next_index == 7'h00) ? tx_right : tx_hold_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_hold_l <= 32'h00000000;
            tx_hold_r <= 32'h00000000;
            tx_taken  <= 1'b0;
        end else begin
            tx_taken <= 1'b0;
            if (launch_ev && next_index == 7'h00) begin
                tx_hold_l <= tx_left;
                tx_hold_r <= tx_right;
                tx_taken  <= serial_output_enable;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sdata_out <= 1'b0;
        end else if (!serial_output_enable) begin
            sdata_out <= 1'b0;
        end else if (launch_ev) begin
            if (!loc_next[6]) begin
                sdata_out <= 1'b0;
            end else if (loc_next[5]) begin
                sdata_out <= src_r[loc_next[4:0]];
            end else begin
                sdata_out <= src_l[loc_next[4:0]];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive: bits are taken on the valid edge; the pair is reported when
    // the last bit of the right word arrives.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_l_sh  <= 32'h00000000;
            rx_r_sh  <= 32'h00000000;
            rx_left  <= 32'h00000000;
            rx_right <= 32'h00000000;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (!serial_input_enable) begin
                rx_l_sh <= 32'h00000000;
                rx_r_sh <= 32'h00000000;
            end else if (valid_ev && loc_now[6] &&
                         frame_state == FR_LOCKED) begin
                if (!loc_now[5]) begin
                    rx_l_sh[loc_now[4:0]] <= sdata_in;
                end else if (loc_now[4:0] != 5'h00) begin
                    rx_r_sh[loc_now[4:0]] <= sdata_in;
                end else begin
                    rx_left  <= rx_l_sh;
                    rx_right <= {rx_r_sh[31:1], sdata_in};
                    rx_valid <= 1'b1;
                    rx_l_sh  <= 32'h00000000;
                    rx_r_sh  <= 32'h00000000;
                end
            end
        end
    end

endmodule

// file: sim/port_checker.sv
// Assertions on the codec serial port's top-level ports.
`timescale 1ns/100ps
module port_checker
    import codec_port_pkg::*;
(
    input wire logic        clk, nrst, hsel, hwrite, hready,
    input wire logic [31:0] haddr, hwdata,
    input wire logic [1:0]  htrans, rate_divider,
    input wire logic [1:0]  base_sample_rate, master_clock_ratio,
    input wire logic [2:0]  hsize,
    input wire logic        record_converter_power_on, pll_clock_select,
    input wire logic        playback_converter_power_on,
    input wire logic        audio_processor_power_on,
    input wire logic        bclk_out, bclk_oe, lrclk_out, lrclk_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire wr = hsel & hready & htrans[1] & hwrite & (hsize == HSIZE_WORD);
    // A write lands at the edge that closes its data phase.
    sequence s_pw;
        wr && haddr == 32'(ADDR_DIG_POWER) ##1 1'b1;
    endsequence
    sequence s_ck;
        wr && haddr == 32'(ADDR_CLK_CTRL) ##1 1'b1;
    endsequence
    a_rec_power: assert property (s_pw |=>
        record_converter_power_on == $past(hwdata[6])) else $error("rec power");
    a_play_power: assert property (s_pw |=>
        playback_converter_power_on == $past(hwdata[5])) else $error("dac power");
    a_dsp_power: assert property (s_pw |=>
        audio_processor_power_on == $past(hwdata[4])) else $error("dsp power");
    a_rate_div: assert property (s_ck |=>
        rate_divider == $past(hwdata[5:4])) else $error("rate divider");
    a_base_rate: assert property (s_ck |=>
        base_sample_rate == $past(hwdata[3:2])) else $error("base rate");
    a_pll_decode: assert property (
        pll_clock_select == (master_clock_ratio == MCLK_USE_PLL))
        else $error("pll select");
    a_clock_dir: assert property (bclk_oe == lrclk_oe)
        else $error("clock enables differ");
    a_slave_quiet: assert property (!bclk_oe |-> !bclk_out && !lrclk_out)
        else $error("clock driven as slave");
endmodule
bind codec_serial_port port_checker u_chk (.*);

// file: sim/audio_partner.sv
// Far-end serial audio partner that echoes the device's data back.
`timescale 1ns/100ps
module audio_partner (
    input  wire logic bclk_out, bclk_oe, lrclk_out, lrclk_oe, sdata_out,
    output logic      bclk_in, lrclk_in, sdata_in
);
    // With the device as slave the partner is clock master: a 64 Fs bit
    // clock, and the frame clock moves on the falling (launch) edge.
    logic sclk = 1'b0;
    logic fclk = 1'b0;
    int   n    = 0;
    always #160 begin
        sclk = ~sclk;
        if (!sclk) begin
            n    = (n + 1) % 64;
            fclk = (n >= 32);
        end
    end
    assign bclk_in  = bclk_oe ? bclk_out : sclk;
    assign lrclk_in = lrclk_oe ? lrclk_out : fclk;
    // The echo lands half a bit period before the device samples it.
    assign sdata_in = sdata_out;
endmodule

// file: sim/testbench.sv
// Self-checking bench: AHB-Lite register tests and serial loopback.
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
    $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module testbench;
    import codec_port_pkg::*;
    logic        clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0, base_sample_rate, rate_divider;
    logic [1:0]  master_clock_ratio;
    logic [2:0]  hsize = HSIZE_WORD;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rx_left, rx_right, q;
    logic [31:0] tx_left = 32'h00abcdef, tx_right = 32'h00123456;
    logic        hreadyout, hresp, pll_clock_select, bclk_out, bclk_oe;
    logic        lrclk_out, lrclk_oe, sdata_out, tx_taken, rx_valid;
    logic        bclk_in, lrclk_in, sdata_in;
    logic        record_converter_power_on, playback_converter_power_on;
    logic        audio_processor_power_on;
    wire         hready = hreadyout;
    wire  [2:0]  pw = {record_converter_power_on,
                       playback_converter_power_on, audio_processor_power_on};
    int          mismatches = 0, n_tests = 0;
    always #5 clk = ~clk;
    codec_serial_port u_dut (.*);
    audio_partner u_far (.*);
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // hrdata is taken at the closing edge; other outputs are sampled 1 ns after it, once it has landed.
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, '0);
        `CHK({hresp, q}, {1'b0, e})
    endtask
    task automatic wait_rx();
        int j = 0;
        do begin @(negedge clk); j++; end while (rx_valid !== 1'b1 && j < 5000);
        `CHK(rx_valid, 1'b1)
    endtask
    initial begin #600000; mismatches++; close_out(); end
    initial begin
        time t;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        rd(ADDR_DIG_POWER, 32'h0);
        rd(ADDR_CLK_CTRL, 32'h8);
        rd(ADDR_PORT_CTRL, 32'h10);
        bus(ADDR_DIG_POWER, 1'b1, '1);
        rd(ADDR_DIG_POWER, 32'h7f);
        `CHK(pw, 3'h7)
        bus(ADDR_PORT_CTRL, 1'b1, 32'h90);
        for (int i = 0; i < 4; i++) begin
            bus(ADDR_CLK_CTRL, 1'b1, 32'(i * 6'h15));
            `CHK({rate_divider, base_sample_rate, master_clock_ratio, pll_clock_select}, {6'(i * 6'h15), 1'(i == 3)})
        end
        bus(ADDR_CLK_CTRL, 1'b1, 32'h8);
        bus(8'h40, 1'b1, '1);
        rd(8'h40, 32'h0);
        bus(ADDR_DIG_POWER, 1'b1, 32'h3);
        `CHK(pw, 3'h0)
        $display("register test done");
        for (int k = 0; k < 3; k++) begin
            bus(ADDR_PORT_CTRL, 1'b1, k == 0 ? 32'h94 :
                k == 1 ? 32'h1f3 : 32'h10);
            `CHK(bclk_oe, 1'(k < 2))
            if (k < 2) begin
                @(posedge bclk_out) t = $time;
                @(posedge bclk_out) `CHK($time - t, k ? 64'h280 : 64'h140)
                @(posedge tx_taken) #1 `CHK(lrclk_out, 1'(k))
            end
            repeat (3) wait_rx();
            `CHK(rx_left, k == 1 ? 32'hcdef : 32'habcdef)
            `CHK(rx_right, k == 1 ? 32'h3456 : 32'h123456)
            $display("serial test %0d done", k);
        end
        bus(ADDR_DIG_POWER, 1'b1, 32'h0);
        repeat (2) @(posedge clk);
        repeat (2200) begin @(negedge clk); `CHK({sdata_out, rx_valid, tx_taken}, 3'h0) end
        $display("disable test done");
        close_out();
    end
endmodule
